// *** rtl/dprc_defs.svh ***
// constants of the pio read command unit
`ifndef DPRC_DEFS_SVH
`define DPRC_DEFS_SVH
// task-file register offsets
`define DPRC_OFS_DATA     4'h0
`define DPRC_OFS_ERROR    4'h1
`define DPRC_OFS_SCOUNT   4'h2
`define DPRC_OFS_SNUM     4'h3
`define DPRC_OFS_CYL_LO   4'h4
`define DPRC_OFS_CYL_HI   4'h5
`define DPRC_OFS_DEVHEAD  4'h6
`define DPRC_OFS_CMD      4'h7
`define DPRC_OFS_CTRL     4'h8
`define DPRC_OFS_IRQ_STAT 4'h9
`define DPRC_OFS_IRQ_MASK 4'hA
// opcodes
`define DPRC_OP_NATMAX    8'h27
`define DPRC_OP_READ28    8'h20
`define DPRC_OP_READ48    8'h24
// field positions
`define DPRC_CTRL_HOB     7
`define DPRC_DH_LBA       6
`define DPRC_ERR_UNC      6
`define DPRC_ERR_IDN      4
`define DPRC_ERR_ABT      2
`define DPRC_ERR_AMN      0
`define DPRC_ST_BSY       7
`define DPRC_ST_RDY       6
`define DPRC_ST_DSC       4
`define DPRC_ST_DRQ       3
`define DPRC_ST_ERR       0
// interrupt status bits
`define DPRC_IRQ_SECTOR   0
`define DPRC_IRQ_DONE     1
// sizes and reset values
`define DPRC_WORDS_PER_SEC 9'd256
`define DPRC_MAX_LBA_RST  48'h0000_0FFF_FFFF
`define DPRC_IDLE_STATUS  8'h50
`endif

// *** rtl/dprc_pkg.sv ***
// types of the pio read command unit
package dprc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_XFER, ST_NEXT, ST_DONE
    } dprc_state_t;
    typedef struct packed {
        logic        req;
        logic [47:0] lba;
    } dprc_media_req_t;
    typedef struct packed {
        logic        valid;
        logic        uncorrectable;
        logic [15:0] word;
    } dprc_media_rsp_t;
endpackage

// *** rtl/dprc_shadow.sv ***
// two-deep history register for one task-file byte
module dprc_shadow
    import dprc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // write side
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    // history
    output logic [7:0]      cur_o,
    output logic [7:0]      prev_o
);
    typedef struct packed {
        logic [7:0] cur;
        logic [7:0] prev;
    } dprc_shadow_st_t;
    dprc_shadow_st_t q_r;
    dprc_shadow_st_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (wr_i) begin
            q_nxt.prev = q_r.cur;
            q_nxt.cur  = wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign cur_o  = q_r.cur;
    assign prev_o = q_r.prev;
endmodule

// *** rtl/dprc_irq.sv ***
// sticky interrupt status with mask, cleared by writing one
module dprc_irq
    import dprc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // events and software access
    input  wire logic [1:0] event_i,
    input  wire logic       stat_wr_i,
    input  wire logic       mask_wr_i,
    input  wire logic [1:0] wdata_i,
    // state
    output logic [1:0]      stat_o,
    output logic [1:0]      mask_o,
    output logic            irq_o
);
    typedef struct packed {
        logic [1:0] stat;
        logic [1:0] mask;
    } dprc_irq_st_t;
    dprc_irq_st_t q_r;
    dprc_irq_st_t q_nxt;

    always_comb begin
        q_nxt = q_r;
        // set wins over a clear in the same cycle
        if (stat_wr_i) begin
            q_nxt.stat = q_r.stat & ~wdata_i;
        end
        q_nxt.stat = q_nxt.stat | event_i;
        if (mask_wr_i) begin
            q_nxt.mask = wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign stat_o = q_r.stat;
    assign mask_o = q_r.mask;
    assign irq_o  = |(q_r.stat & q_r.mask);
endmodule

// *** rtl/dprc_top.sv ***
// pio read command unit: native max query and 28/48-bit sector reads
//
// Added by the designer: the strobed register port and the placing of the registers.
`include "dprc_defs.svh"
module dprc_top
    import dprc_pkg::*;
#(
    parameter logic [47:0] NATIVE_MAX_LBA = `DPRC_MAX_LBA_RST
)(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // media port
    output dprc_media_req_t  media_req_o,
    input  wire dprc_media_rsp_t media_rsp_i,
    output logic             media_ready_o,
    // interrupt
    output logic             irq_o
);
    typedef struct packed {
        dprc_state_t state;
        logic        ext;
        logic        lba_mode;
        logic [16:0] remain;
        logic [47:0] cur_lba;
        logic [47:0] res_lba;
        logic [7:0]  res_cnt_lo;
        logic [7:0]  res_cnt_hi;
        logic        res_valid;
        logic [7:0]  err;
        logic [7:0]  status;
        logic        high_order_byte_select;
        logic [15:0] buf_word;
        logic [8:0]  words_left;
        logic        buf_full;
        logic [15:0] rdata;
        logic        sector_evt;
        logic        done_evt;
    } dprc_st_t;
    dprc_st_t q_r;
    dprc_st_t q_nxt;

    logic [7:0] sc_cur, sc_prev, sn_cur, sn_prev;
    logic [7:0] cl_cur, cl_prev, ch_cur, ch_prev;
    logic [7:0] dh_r;
    logic [1:0] irq_stat, irq_mask;
    logic       wr_sc, wr_sn, wr_cl, wr_ch, cmd_wr, busy, data_rd;

    // bank select of a 48-bit value by the high byte select
    function automatic logic [7:0] bank(input logic [47:0] v,
                                        input logic high_order_byte_select,
                                        input int   idx);
        logic [47:0] s;
        s = high_order_byte_select ? (v >> 24) : v;
        return s[idx*8 +: 8];
    endfunction

    assign busy   = q_r.state != ST_IDLE && q_r.state != ST_DONE;
    assign wr_sc  = wr_i && addr_i == `DPRC_OFS_SCOUNT && !busy;
    assign wr_sn  = wr_i && addr_i == `DPRC_OFS_SNUM && !busy;
    assign wr_cl  = wr_i && addr_i == `DPRC_OFS_CYL_LO && !busy;
    assign wr_ch  = wr_i && addr_i == `DPRC_OFS_CYL_HI && !busy;
    assign cmd_wr = wr_i && addr_i == `DPRC_OFS_CMD && !busy;
    assign data_rd = rd_i && addr_i == `DPRC_OFS_DATA
                     && q_r.state == ST_XFER && q_r.buf_full;

    dprc_shadow u_sc (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr_sc),
        .wdata_i(wdata_i), .cur_o(sc_cur), .prev_o(sc_prev));
    dprc_shadow u_sn (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr_sn),
        .wdata_i(wdata_i), .cur_o(sn_cur), .prev_o(sn_prev));
    dprc_shadow u_cl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr_cl),
        .wdata_i(wdata_i), .cur_o(cl_cur), .prev_o(cl_prev));
    dprc_shadow u_ch (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wr_i(wr_ch),
        .wdata_i(wdata_i), .cur_o(ch_cur), .prev_o(ch_prev));

    dprc_irq u_irq (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .event_i({q_r.done_evt, q_r.sector_evt}),
        .stat_wr_i(wr_i && addr_i == `DPRC_OFS_IRQ_STAT),
        .mask_wr_i(wr_i && addr_i == `DPRC_OFS_IRQ_MASK),
        .wdata_i(wdata_i[1:0]), .stat_o(irq_stat), .mask_o(irq_mask),
        .irq_o(irq_o));

    // device/head byte kept apart
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dh_r <= 8'hA0;
        end else if (wr_i && addr_i == `DPRC_OFS_DEVHEAD && !busy) begin
            dh_r <= wdata_i;
        end
    end

    always_comb begin
        q_nxt = q_r;
        q_nxt.sector_evt = 1'b0;
        q_nxt.done_evt   = 1'b0;
        if (wr_i && addr_i == `DPRC_OFS_CTRL) begin
            q_nxt.high_order_byte_select = wdata_i[`DPRC_CTRL_HOB];
        end
        case (q_r.state)
            ST_IDLE, ST_DONE: begin
                if (cmd_wr) begin
                    q_nxt.err = 8'h00;
                    q_nxt.res_valid = 1'b0;
                    q_nxt.lba_mode = dh_r[`DPRC_DH_LBA];
                    if (wdata_i == `DPRC_OP_NATMAX) begin
                        // true maximum, no set-max limit applied
                        q_nxt.res_lba = NATIVE_MAX_LBA;
                        q_nxt.res_valid = 1'b1;
                        q_nxt.status = `DPRC_IDLE_STATUS;
                        q_nxt.done_evt = 1'b1;
                        q_nxt.state = ST_DONE;
                    end else if (wdata_i[7:1]
                                 == 7'(`DPRC_OP_READ28 >> 1)) begin
                        // low bit of opcode ignored
                        q_nxt.ext = 1'b0;
                        // zero count means 256
                        q_nxt.remain = (sc_cur == 8'h00) ? 17'd256
                                                        : {9'd0, sc_cur};
                        // block location in either mode, lba_mode not consulted
                        q_nxt.cur_lba = {20'd0, dh_r[3:0], ch_cur,
                                         cl_cur, sn_cur};
                        q_nxt.state = ST_FETCH;
                    end else if (wdata_i == `DPRC_OP_READ48) begin
                        q_nxt.ext = 1'b1;
                        // 16-bit count, zero means 65,536
                        q_nxt.remain = ({sc_prev, sc_cur} == 16'h0000)
                            ? 17'h10000 : {1'b0, sc_prev, sc_cur};
                        // address from two-deep history
                        q_nxt.cur_lba = {ch_prev, cl_prev, sn_prev,
                                         ch_cur, cl_cur, sn_cur};
                        q_nxt.state = ST_FETCH;
                    end else begin
                        q_nxt.err[`DPRC_ERR_ABT] = 1'b1;
                        q_nxt.status = `DPRC_IDLE_STATUS | 8'h01;
                        q_nxt.done_evt = 1'b1;
                        q_nxt.state = ST_DONE;
                    end
                    if (q_nxt.state == ST_FETCH) begin
                        q_nxt.status = 8'h80;
                        q_nxt.words_left = `DPRC_WORDS_PER_SEC;
                        q_nxt.buf_full = 1'b0;
                    end
                end
            end
            ST_FETCH: begin
                // fetch from media before handing out words
                if (media_rsp_i.valid) begin
                    if (media_rsp_i.uncorrectable) begin
                        // stop at failing sector
                        q_nxt.err[`DPRC_ERR_UNC] = 1'b1;
                        // 28-bit keeps the last good sector
                        if (q_r.ext) begin
                            q_nxt.res_lba = q_r.cur_lba;
                        end
                        q_nxt.res_valid = 1'b1;
                        q_nxt.status = `DPRC_IDLE_STATUS | 8'h01;
                        q_nxt.done_evt = 1'b1;
                        q_nxt.state = ST_DONE;
                    end else begin
                        q_nxt.buf_word = media_rsp_i.word;
                        q_nxt.buf_full = 1'b1;
                        q_nxt.words_left = q_r.words_left - 9'd1;
                        // data request with busy clear
                        q_nxt.status = `DPRC_IDLE_STATUS | 8'h08;
                        q_nxt.state = ST_XFER;
                        if (q_r.words_left == `DPRC_WORDS_PER_SEC) begin
                            // interrupt per sector
                            q_nxt.sector_evt = 1'b1;
                        end
                    end
                end
            end
            ST_XFER: begin
                if (data_rd) begin
                    // 16-bit data word leaves through data register
                    q_nxt.buf_full = 1'b0;
                    if (q_r.words_left == 9'd0) begin
                        q_nxt.state = ST_NEXT;
                        q_nxt.status = 8'h80;
                    end else begin
                        // busy again while the next word is fetched
                        q_nxt.status = 8'h80;
                        q_nxt.state = ST_FETCH;
                    end
                end
            end
            ST_NEXT: begin
                q_nxt.remain = q_r.remain - 17'd1;
                if (!q_r.ext) begin
                    // last transferred sector location
                    q_nxt.res_lba = q_r.cur_lba;
                end
                if (q_r.remain == 17'd1) begin
                    // completion: busy and data request clear
                    q_nxt.status = `DPRC_IDLE_STATUS;
                    q_nxt.done_evt = 1'b1;
                    q_nxt.state = ST_DONE;
                end else begin
                    q_nxt.cur_lba = q_r.cur_lba + 48'd1;
                    q_nxt.words_left = `DPRC_WORDS_PER_SEC;
                    q_nxt.state = ST_FETCH;
                end
            end
            default: q_nxt.state = ST_IDLE;
        endcase
        // residual count of sectors not transferred
        q_nxt.res_cnt_lo = q_nxt.remain[7:0];
        q_nxt.res_cnt_hi = q_nxt.remain[15:8];
        if (rd_i) begin
            q_nxt.rdata = 16'h0000;
            case (addr_i)
                `DPRC_OFS_DATA:   q_nxt.rdata = data_rd ? q_r.buf_word
                                                         : 16'h0000;
                `DPRC_OFS_ERROR:  q_nxt.rdata = {8'h00, q_r.err};
                `DPRC_OFS_SCOUNT: q_nxt.rdata = {8'h00, q_r.high_order_byte_select
                                  ? q_r.res_cnt_hi : q_r.res_cnt_lo};
                // banks of native max, last transferred sector or error address
                `DPRC_OFS_SNUM:   q_nxt.rdata = {8'h00,
                                  bank(q_r.res_lba, q_r.high_order_byte_select, 0)};
                `DPRC_OFS_CYL_LO: q_nxt.rdata = {8'h00,
                                  bank(q_r.res_lba, q_r.high_order_byte_select, 1)};
                `DPRC_OFS_CYL_HI: q_nxt.rdata = {8'h00,
                                  bank(q_r.res_lba, q_r.high_order_byte_select, 2)};
                `DPRC_OFS_DEVHEAD: q_nxt.rdata = {8'h00, dh_r[7:4],
                                  q_r.res_lba[27:24]};
                `DPRC_OFS_CMD:    q_nxt.rdata = {8'h00, q_r.status};
                `DPRC_OFS_CTRL:   q_nxt.rdata = {8'h00, q_r.high_order_byte_select, 7'h00};
                `DPRC_OFS_IRQ_STAT: q_nxt.rdata = {14'h0, irq_stat};
                `DPRC_OFS_IRQ_MASK: q_nxt.rdata = {14'h0, irq_mask};
                default:          q_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_r <= '{state: ST_IDLE, status: `DPRC_IDLE_STATUS, default: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign rdata_o = q_r.rdata;
    assign media_req_o.req = q_r.state == ST_FETCH && !q_r.buf_full;
    assign media_req_o.lba = q_r.cur_lba;
    assign media_ready_o = q_r.state == ST_FETCH;

    // a 48-bit read that starts goes busy at once
    a_cmd_busy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cmd_wr && wdata_i == `DPRC_OP_READ48) |=> q_r.status[7])
        else $error("read command did not raise busy");
    a_drq_nobusy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        q_r.status[3] |-> !q_r.status[7])
        else $error("data request with busy set");
    a_unc_stop: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (q_r.state == ST_FETCH && media_rsp_i.valid
         && media_rsp_i.uncorrectable) |=> q_r.state == ST_DONE)
        else $error("transfer went on after media error");
    a_natmax_val: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cmd_wr && wdata_i == `DPRC_OP_NATMAX)
        |=> q_r.res_lba == NATIVE_MAX_LBA)
        else $error("native max value wrong");
    a_zero_256: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (cmd_wr && wdata_i[7:1] == 7'h10 && sc_cur == 8'h00)
        |=> q_r.remain == 17'd256)
        else $error("zero count not taken as 256");
    a_sector_irq: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        q_r.sector_evt |-> q_r.state == ST_XFER)
        else $error("sector interrupt outside transfer");
    a_done_clear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (q_r.state == ST_NEXT && q_r.remain == 17'd1)
        |=> !q_r.status[7] && !q_r.status[3] && q_r.remain == 17'd0)
        else $error("completion status or residual wrong");
    a_word_order: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        data_rd |=> rdata_o == $past(q_r.buf_word))
        else $error("data word not presented");
    a_unc_flag: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (q_r.state == ST_FETCH && media_rsp_i.valid
         && media_rsp_i.uncorrectable) |=> q_r.err[`DPRC_ERR_UNC])
        else $error("media error not flagged");
    a_fetch_busy: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        q_r.state == ST_FETCH |-> q_r.status[7] && !q_r.status[3])
        else $error("fetch without busy");
    a_last_lba: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (q_r.state == ST_NEXT && !q_r.ext)
        |=> q_r.res_lba == $past(q_r.cur_lba))
        else $error("last sector address not kept");
endmodule

// *** tb/dprc_media_model.sv ***
// behavioural media model answering word requests of the read unit
module dprc_media_model
    import dprc_pkg::*;
(
    // clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            nrst_i,
    // media port of the unit
    input  wire dprc_media_req_t media_req_i,
    input  wire logic            media_ready_i,
    output dprc_media_rsp_t      media_rsp_o,
    // scenario control
    input  wire logic            err_en_i,
    input  wire logic [47:0]     err_lba_i,
    input  wire logic [1:0]      delay_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  idx;
    logic [7:0]  w_idx;
    logic [15:0] fold;
    logic [47:0] last_lba;
    logic [1:0]  wait_cnt;

    // word count restarts on each new sector address
    assign w_idx = (media_req_i.lba == last_lba) ? idx : 8'h00;
    assign fold  = media_req_i.lba[15:0] ^ media_req_i.lba[31:16]
                 ^ media_req_i.lba[47:32];

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            media_rsp_o <= '0;
            idx         <= 8'h00;
            last_lba    <= '1;
            wait_cnt    <= 2'h0;
        end else begin
            media_rsp_o.valid         <= 1'b0;
            media_rsp_o.uncorrectable <= 1'b0;
            // idle word toggles so a stale value never passes
            media_rsp_o.word          <= ~media_rsp_o.word;
            if (media_req_i.req && media_ready_i && !media_rsp_o.valid) begin
                if (wait_cnt != delay_i) begin
                    wait_cnt <= wait_cnt + 2'h1;
                end else begin
                    wait_cnt          <= 2'h0;
                    media_rsp_o.valid <= 1'b1;
                    media_rsp_o.word  <= fold ^ {8'h00, w_idx};
                    idx               <= w_idx + 8'h01;
                    last_lba          <= media_req_i.lba;
                    if (err_en_i && media_req_i.lba == err_lba_i) begin
                        media_rsp_o.uncorrectable <= 1'b1;
                        last_lba                  <= '1;
                    end
                end
            end
        end
    end
endmodule

// *** tb/dprc_top_tb.sv ***
// self-checking bench of the pio read command unit
module dprc_top_tb
    import dprc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  op;
        logic [15:0] cnt;
        logic [7:0]  nxf;
        logic        err;
        logic        lm;
    } dprc_case_t;
    localparam logic [47:0] NMAX = 48'hA1B2_C3D4_E5F6;
    localparam dprc_case_t CASES [6] = '{
        '{8'h20, 16'h0002, 8'h02, 1'b0, 1'b1},
        '{8'h21, 16'h0001, 8'h01, 1'b0, 1'b0},
        '{8'h20, 16'h0000, 8'h01, 1'b1, 1'b1},
        '{8'h24, 16'h0002, 8'h02, 1'b0, 1'b1},
        '{8'h24, 16'h0100, 8'h01, 1'b1, 1'b1},
        '{8'h24, 16'h0000, 8'h00, 1'b1, 1'b1}
    };
    logic            clk_sys_i;
    logic            nrst_i;
    logic [3:0]      addr_i;
    logic [7:0]      wdata_i;
    logic            wr_i;
    logic            rd_i;
    logic [15:0]     rdata_o;
    dprc_media_req_t media_req_o;
    dprc_media_rsp_t media_rsp_i;
    logic            media_ready_o;
    logic            irq_o;
    logic            err_en;
    logic [47:0]     err_lba;
    logic [1:0]      delay;
    logic [15:0]     rv;
    int              error_cnt;
    int              total_checks;
    integer          seed;

    dprc_top #(.NATIVE_MAX_LBA(NMAX)) i_dprc_top (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .media_req_o(media_req_o), .media_rsp_i(media_rsp_i),
        .media_ready_o(media_ready_o), .irq_o(irq_o));
    dprc_media_model i_dprc_media_model (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .media_req_i(media_req_o),
        .media_ready_i(media_ready_o), .media_rsp_o(media_rsp_i),
        .err_en_i(err_en), .err_lba_i(err_lba), .delay_i(delay));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic finish_test;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        rv = rdata_o;
    endtask

    task automatic wait_ready(output logic [7:0] st);
        int n;
        n = 0;
        do begin
            rd(4'h7);
            st = rv[7:0];
            n++;
        end while (st[7] && n < 400);
        if (st[7]) begin
            error_cnt++;
            finish_test();
        end
    endtask

    function automatic logic [15:0] wexp(input logic [47:0] l, input int w);
        return l[15:0] ^ l[31:16] ^ l[47:32] ^ {8'h00, 8'(w)};
    endfunction

    task automatic issue(input logic [7:0] op, input logic [15:0] cnt,
                         input logic [47:0] l, input logic lm);
        if (op == 8'h24) begin
            wr(4'h2, cnt[15:8]);
            for (int i = 0; i < 3; i++) begin
                wr(4'(3 + i), l[24 + 8*i +: 8]);
            end
        end
        wr(4'h2, cnt[7:0]);
        for (int i = 0; i < 3; i++) begin
            wr(4'(3 + i), l[8*i +: 8]);
        end
        wr(4'h6, {1'b1, lm, 2'b10, l[27:24]});
        wr(4'h7, op);
    endtask

    task automatic chk_addr(input logic [47:0] l, input int nb);
        logic [15:0] e;
        for (int h = 0; h < nb; h++) begin
            wr(4'h8, {h[0], 7'h00});
            for (int r = 0; r < 3; r++) begin
                rd(4'(3 + r));
                e = {8'h00, l[24*h + 8*r +: 8]};
                chk("addr", e, rv & 16'h00FF);
            end
        end
        wr(4'h8, 8'h00);
    endtask

    task automatic done_irq(input logic en);
        rd(4'h9);
        chk("irq status", 16'h0002, rv & 16'h0002);
        chk("irq line", {15'h0, en}, {15'h0, irq_o});
        wr(4'h9, 8'h03);
        rd(4'h9);
        chk("irq clear", 16'h0000, rv & 16'h0003 | {15'h0, irq_o});
    endtask

    task automatic xfer(input logic [47:0] l, input int nxf, input logic err);
        logic [7:0] st;
        for (int s = 0; s < nxf; s++) begin
            for (int w = 0; w < 256; w++) begin
                wait_ready(st);
                chk("data request", 16'h0008, {8'h00, st & 8'h08});
                if (w == 0 || w == 128) begin
                    rd(4'h9);
                    chk("sector irq", {15'h0, w == 0}, rv & 16'h0001);
                    wr(4'h9, 8'h01);
                end
                rd(4'h0);
                chk("data", wexp(l + 48'(s), w), rv);
            end
        end
        wait_ready(st);
        chk("end status", err ? 16'h0051 : 16'h0050, {8'h00, st});
    endtask

    initial begin
        dprc_case_t  c;
        logic [47:0] l;
        logic [15:0] res;
        logic [7:0]  st;
        logic [7:0]  op;
        seed         = 32'h80c6561d;
        error_cnt    = 0;
        total_checks = 0;
        nrst_i       = 1'b0;
        addr_i       = 4'h0;
        wdata_i      = 8'h00;
        wr_i         = 1'b0;
        rd_i         = 1'b0;
        err_en       = 1'b0;
        err_lba      = '0;
        delay        = 2'h0;
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        rd(4'h7);
        chk("idle status", 16'h0050, rv & 16'h00FF);
        wr(4'hA, 8'h03);
        issue(8'h27, 16'h0000, 48'h0, 1'b1);
        wait_ready(st);
        chk_addr(NMAX, 2);
        done_irq(1'b1);
        // unknown opcode is refused
        op = 8'h20;
        while (op inside {8'h20, 8'h21, 8'h24, 8'h27}) begin
            op = 8'($random(seed));
        end
        issue(op, 16'h0001, 48'h0, 1'b1);
        wait_ready(st);
        chk("refused status", 16'h0051, {8'h00, st});
        rd(4'h1);
        chk("refused flags", 16'h0004, rv & 16'h0004);
        done_irq(1'b1);
        foreach (CASES[k]) begin
            c = CASES[k];
            l = {16'($random(seed)), 32'($random(seed))};
            if (c.op != 8'h24) begin
                l = {21'h0, l[26:0]};
            end
            delay   <= 2'($random(seed));
            err_lba <= l + 48'(c.nxf);
            err_en  <= c.err;
            issue(c.op, c.cnt, l, c.lm);
            xfer(l, int'(c.nxf), c.err);
            rd(4'h1);
            chk("error flags", {9'h0, c.err, 6'h0}, rv & 16'h0040);
            if (c.op == 8'h24) begin
                if (c.err) begin
                    chk_addr(l + 48'(c.nxf), 2);
                end
            end else begin
                res = (c.cnt[7:0] == 8'h00) ? 16'd256 : c.cnt;
                res = res - 16'(c.nxf);
                rd(4'h2);
                chk("residual", res & 16'h00FF, rv & 16'h00FF);
                l = l + 48'(c.nxf) - 48'h1;
                chk_addr(l, 1);
                rd(4'h6);
                chk("head", {12'h0, l[27:24]}, rv & 16'h000F);
            end
            done_irq(1'b1);
        end
        wr(4'hA, 8'h00);
        issue(8'h27, 16'h0000, 48'h0, 1'b0);
        wait_ready(st);
        done_irq(1'b0);
        rd(4'hF);
        finish_test();
    end
endmodule
